// ### pkg/fetch_pipe_pkg.sv
package fetch_pipe_pkg;

  localparam int PC_W = 21;
  localparam int PW_W = 16;
  localparam int DB_W = 8;
  localparam int DA_W = 12;

  // gray order along the only path q1 -> q2 -> q3 -> q4
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } phase_t;

  localparam logic [3:0] PHASE_CLK_RST = 4'h1;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PW_W-1:0] IR_RST = 16'h0000;
  localparam logic [DB_W-1:0] BYTE_RST = 8'h00;
  localparam logic [DA_W-1:0] DADDR_RST = 12'h000;

  // opcode fields
  localparam logic [PW_W-1:0] OP_TBLRD = 16'h0008;
  localparam logic [7:0] OPB_RET_LIT = 8'h0c;
  localparam logic [7:0] OPB_MOVLW = 8'h0e;
  localparam logic [7:0] OPB_GOTO = 8'hef;
  localparam logic [7:0] OPB_LFSR = 8'hee;
  localparam logic [1:0] LFSR_ZERO = 2'h0;
  localparam logic [6:0] OPT_CALL = 7'h76;
  localparam logic [6:0] OPT_TEST_SKIP = 7'h33;
  localparam logic [5:0] OPT_ADD_W = 6'h09;
  localparam logic [4:0] OPT_BRA = 5'h1a;
  localparam logic [3:0] OPT_FILE_MOVE = 4'hc;
  localparam logic [3:0] OPT_OPERAND = 4'hf;

  // data addressing
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] PC_LOW_OFFSET = 8'hf9;
  localparam logic [3:0] SFR_BANK = 4'hf;
  localparam logic [3:0] GPR_BANK = 4'h0;

  function automatic logic [DA_W-1:0] data_addr_f(
    input logic banked,
    input logic [7:0] f,
    input logic [3:0] bank
  );
    logic [3:0] hi;
    hi = (f < ACCESS_SPLIT) ? GPR_BANK : SFR_BANK;
    if (banked) begin
      hi = bank;
    end
    return {hi, f};
  endfunction

endpackage

// ### hdl/fetch_pipe.sv
`timescale 1ns/10ps
// How it works
// RULE_01: a gray phase counter splits the core clock into four one-hot phases.
// RULE_02: the pc steps at the q1 edge and the fetched word is latched at q4.
// RULE_03: the prefetched word enters the instruction register at q1.
// RULE_04: operands are read from data memory at q2 and results written at q4.
// RULE_05: fetching the next word overlaps execution of the current one.
// RULE_06: a pc change drops the prefetched word so the change costs two cycles.
// RULE_07: program memory is byte addressed with words at even addresses.
// RULE_08: the pc moves in steps of two and its low bit is always zero.
// RULE_09: jump and call load their word address into pc bits 20 to 1.
// RULE_10: a relative branch offset counts instruction words, not bytes.
// RULE_11: call, move, jump and pointer load take a second word tagged 1111.
// RULE_12: a 1111 word is operand after its first word, else a no-operation.
// RULE_13: adding the working register to the pc low byte advances the pc.
// RULE_14: return-with-literal pops the stack and puts its byte in w.
// RULE_15: a table read fetches one byte at the table pointer address.
// RULE_16: after reset the phase is q1 and no prefetched word is valid.
module fetch_pipe
  import fetch_pipe_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [PW_W-1:0] pmem_rdata_i,
  input wire logic [DB_W-1:0] dmem_rdata_i,
  input wire logic [3:0] bank_i,
  input wire logic [PC_W-1:0] tos_i,
  input wire logic [PC_W-1:0] table_pointer_i,
  output logic [3:0] phase_clk_o,
  output logic [PC_W-2:0] pmem_addr_o,
  output logic [DA_W-1:0] dmem_addr_o,
  output logic dmem_re_o,
  output logic dmem_we_o,
  output logic [DB_W-1:0] dmem_wdata_o,
  output logic stack_push_o,
  output logic stack_pop_o,
  output logic [PC_W-1:0] return_addr_o,
  output logic [DB_W-1:0] table_latch_o,
  output logic pointer_load_o,
  output logic [1:0] pointer_sel_o,
  output logic [DA_W-1:0] pointer_value_o,
  output logic [DB_W-1:0] working_register_o,
  output logic [PC_W-1:0] program_counter_o
);

  phase_t phase_ff;
  phase_t nxt_phase;
  logic [3:0] phase_clk_ff;
  logic [PC_W-1:0] pc_ff;
  logic [PC_W-2:0] pmem_addr_ff;
  logic [PW_W-1:0] fetch_latch_ff;
  logic fetch_valid_ff;
  logic [PW_W-1:0] instruction_register_ff;
  logic exec_valid_ff;
  logic second_ff;
  logic tbl_slot_ff;
  logic [DB_W-1:0] operand_ff;
  logic [DB_W-1:0] working_register_ff;
  logic [DA_W-1:0] dmem_addr_ff;
  logic dmem_re_ff;
  logic dmem_we_ff;
  logic [DB_W-1:0] dmem_wdata_ff;
  logic stack_push_ff;
  logic stack_pop_ff;
  logic [PC_W-1:0] return_addr_ff;
  logic [DB_W-1:0] table_latch_ff;
  logic pointer_load_ff;
  logic [1:0] pointer_sel_ff;
  logic [DA_W-1:0] pointer_value_ff;

  wire in_q1 = (phase_ff == PH_Q1);
  wire in_q2 = (phase_ff == PH_Q2);
  wire in_q3 = (phase_ff == PH_Q3);
  wire in_q4 = (phase_ff == PH_Q4);

  // instruction fields, named once
  wire [PW_W-1:0] instr = instruction_register_ff;
  wire dest_file = instr[9];
  wire use_bank = instr[8];
  wire [7:0] file_low = instr[7:0];
  wire [7:0] lit_byte = instr[7:0];
  wire [10:0] bra_offset = instr[10:0];

  // a consumed second word never decodes as an instruction of its own
  wire ex = exec_valid_ff & ~second_ff; // RULE_12
  wire is_goto = ex & (instr[15:8] == OPB_GOTO);
  wire is_call = ex & (instr[15:9] == OPT_CALL);
  wire is_lfsr = ex & (instr[15:8] == OPB_LFSR)
    & (instr[7:6] == LFSR_ZERO);
  wire is_file_move = ex & (instr[15:12] == OPT_FILE_MOVE);
  wire is_add_w = ex & (instr[15:10] == OPT_ADD_W);
  wire is_test_skip = ex & (instr[15:9] == OPT_TEST_SKIP);
  wire is_bra = ex & (instr[15:11] == OPT_BRA);
  wire is_ret_lit = ex & (instr[15:8] == OPB_RET_LIT);
  wire is_movlw = ex & (instr[15:8] == OPB_MOVLW);
  wire two_word = is_goto | is_call | is_lfsr | is_file_move; // RULE_11
  // the second word is still on the memory bus at q4 of its first word
  wire [PW_W-1:0] op_word = pmem_rdata_i;
  wire op_word_ok = (op_word[15:12] == OPT_OPERAND); // RULE_11

  wire [DA_W-1:0] file_addr = data_addr_f(use_bank, file_low, bank_i);
  wire [DA_W-1:0] pc_low_addr = {SFR_BANK, PC_LOW_OFFSET};
  wire to_pc_low = is_add_w & dest_file & (file_addr == pc_low_addr);
  wire [DB_W-1:0] sum = operand_ff + working_register_ff;

  // pc already points two words on; the visible pc is the next word
  wire [PC_W-1:0] base_pc = pc_ff - PC_STEP;
  wire [DB_W-1:0] pc_low_sum = base_pc[7:0] + working_register_ff;
  // low byte only, like a plain write to the low pc byte; bit 0 forced low
  wire [PC_W-1:0] pc_low_target =
    {base_pc[20:8], pc_low_sum[7:1], 1'b0}; // RULE_13
  wire [PC_W-1:0] bra_step = {{9{bra_offset[10]}}, bra_offset, 1'b0};
  wire [PC_W-1:0] bra_target = base_pc + bra_step; // RULE_10
  wire [PC_W-1:0] abs_target = {op_word[11:0], lit_byte, 1'b0}; // RULE_09
  wire [PC_W-1:0] ret_target = {tos_i[20:1], 1'b0}; // RULE_14
  wire abs_jump = (is_goto | is_call) & op_word_ok;
  wire jump = abs_jump | is_bra | is_ret_lit | to_pc_low; // RULE_06
  // a bad second word turns call and goto into plain fall-through
  wire [PC_W-1:0] jump_target =
    abs_jump ? abs_target :
    is_bra ? bra_target :
    is_ret_lit ? ret_target : pc_low_target;

  // a zero operand drops the prefetched word
  wire skip = is_test_skip & (operand_ff == BYTE_RST);
  wire tbl_start = fetch_valid_ff & (fetch_latch_ff == OP_TBLRD); // RULE_15
  // a table read borrows the next fetch slot and holds the pc
  wire [PC_W-2:0] fetch_addr =
    tbl_start ? table_pointer_i[PC_W-1:1] : pc_ff[PC_W-1:1]; // RULE_15
  wire need_read = (is_add_w & ~to_pc_low) | is_test_skip | is_file_move;
  wire [DA_W-1:0] read_addr = is_file_move ? instr[11:0] : file_addr;
  wire [DB_W-1:0] tbl_byte =
    table_pointer_i[0] ? pmem_rdata_i[15:8] : pmem_rdata_i[7:0]; // RULE_07
  wire add_to_file = is_add_w & dest_file & ~to_pc_low;
  wire move_write = is_file_move & op_word_ok;

  always_comb begin
    case (phase_ff)
      PH_Q1: nxt_phase = PH_Q2;
      PH_Q2: nxt_phase = PH_Q3;
      PH_Q3: nxt_phase = PH_Q4;
      PH_Q4: nxt_phase = PH_Q1;
      default: nxt_phase = PH_Q1;
    endcase
  end

  // both phase views restart at q1, so the first edge is a fetch
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_ff <= PH_Q1; // RULE_16
      phase_clk_ff <= PHASE_CLK_RST;
    end else begin
      phase_ff <= nxt_phase; // RULE_01
      phase_clk_ff <= {phase_clk_ff[2:0], phase_clk_ff[3]}; // RULE_01
    end
  end

  // pc steps at q1 unless a table read holds it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pc_ff <= PC_RST;
    end else if (in_q1 & ~tbl_start) begin
      pc_ff <= pc_ff + PC_STEP; // RULE_02 RULE_08
    end else if (in_q4 & jump) begin
      pc_ff <= jump_target; // RULE_06 RULE_08
    end
  end

  // program address stands for the whole instruction cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pmem_addr_ff <= PC_RST[PC_W-1:1];
      tbl_slot_ff <= 1'b0;
    end else if (in_q1) begin
      tbl_slot_ff <= tbl_start; // RULE_15
      pmem_addr_ff <= fetch_addr; // RULE_07
    end else if (in_q4) begin
      tbl_slot_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fetch_latch_ff <= IR_RST;
      fetch_valid_ff <= 1'b0; // RULE_16
    end else if (in_q4) begin
      fetch_latch_ff <= pmem_rdata_i; // RULE_02 RULE_05
      // a jump, a skip or a table slot leaves a bubble
      fetch_valid_ff <= ~(tbl_slot_ff | jump | skip); // RULE_06
    end
  end

  // the odd pointer bit picks the high byte lane
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      table_latch_ff <= BYTE_RST;
    end else if (in_q4 & tbl_slot_ff) begin
      table_latch_ff <= tbl_byte; // RULE_15
    end
  end

  // execute side
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      instruction_register_ff <= IR_RST;
      exec_valid_ff <= 1'b0; // RULE_16
      second_ff <= 1'b0;
    end else if (in_q1) begin
      instruction_register_ff <= fetch_latch_ff; // RULE_03
      exec_valid_ff <= fetch_valid_ff & ~tbl_start; // RULE_03
      second_ff <= two_word & fetch_valid_ff; // RULE_12
    end
  end

  // operand taken one cycle after the read strobe rises
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      operand_ff <= BYTE_RST;
    end else if (in_q3) begin
      operand_ff <= dmem_rdata_i; // RULE_04
    end
  end

  // an add with the destination bit clear lands in w, not in memory
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      working_register_ff <= BYTE_RST;
    end else if (in_q4 & is_add_w & ~dest_file) begin
      working_register_ff <= sum;
    end else if (in_q4 & (is_movlw | is_ret_lit)) begin
      working_register_ff <= lit_byte; // RULE_14
    end
  end

  // one-cycle strobes toward memory, stack and pointer file
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dmem_re_ff <= 1'b0;
      dmem_we_ff <= 1'b0;
      stack_push_ff <= 1'b0;
      stack_pop_ff <= 1'b0;
      pointer_load_ff <= 1'b0;
    end else begin
      dmem_re_ff <= in_q2 & need_read; // RULE_04
      dmem_we_ff <= in_q4 & (add_to_file | move_write); // RULE_04
      stack_push_ff <= in_q4 & is_call & op_word_ok;
      stack_pop_ff <= in_q4 & is_ret_lit; // RULE_14
      pointer_load_ff <= in_q4 & is_lfsr & op_word_ok; // RULE_11
    end
  end

  // address and write data stand until the next access
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dmem_addr_ff <= DADDR_RST;
      dmem_wdata_ff <= BYTE_RST;
    end else if (in_q2 & need_read) begin
      dmem_addr_ff <= read_addr; // RULE_04
    end else if (in_q4 & move_write) begin
      dmem_addr_ff <= op_word[11:0]; // RULE_11
      dmem_wdata_ff <= operand_ff;
    end else if (in_q4 & add_to_file) begin
      dmem_addr_ff <= file_addr;
      dmem_wdata_ff <= sum;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      return_addr_ff <= PC_RST;
    end else if (in_q4 & is_call) begin
      // pc has already passed the second word
      return_addr_ff <= pc_ff;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pointer_sel_ff <= 2'h0;
      pointer_value_ff <= DADDR_RST;
    end else if (in_q4 & is_lfsr) begin
      pointer_sel_ff <= instr[5:4];
      pointer_value_ff <= {instr[3:0], op_word[7:0]}; // RULE_11
    end
  end

  // every output comes straight from a flop

  assign phase_clk_o = phase_clk_ff;
  assign pmem_addr_o = pmem_addr_ff;
  assign dmem_addr_o = dmem_addr_ff;
  assign dmem_re_o = dmem_re_ff;
  assign dmem_we_o = dmem_we_ff;
  assign dmem_wdata_o = dmem_wdata_ff;
  assign stack_push_o = stack_push_ff;
  assign stack_pop_o = stack_pop_ff;
  assign return_addr_o = return_addr_ff;
  assign table_latch_o = table_latch_ff;
  assign pointer_load_o = pointer_load_ff;
  assign pointer_sel_o = pointer_sel_ff;
  assign pointer_value_o = pointer_value_ff;
  assign working_register_o = working_register_ff;
  assign program_counter_o = pc_ff;

endmodule

// ### verif/fetch_pipe_properties.sv
`timescale 1ns/10ps
module fetch_pipe_properties
  import fetch_pipe_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] phase_clk_o,
  input wire logic [PC_W-2:0] pmem_addr_o,
  input wire logic dmem_re_o,
  input wire logic dmem_we_o,
  input wire logic [PC_W-1:0] program_counter_o
);
  wire q1 = phase_clk_o[0];
  wire q2 = phase_clk_o[1];
  wire q4 = phase_clk_o[3];
  wire q1q4 = q1 | q4;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_walk;
    phase_clk_o == 4'h2 ##1 phase_clk_o == 4'h4
    ##1 phase_clk_o == 4'h8 ##1 phase_clk_o == 4'h1;
  endsequence
  chk_phase_walk: assert property (
    phase_clk_o == 4'h1 |=> s_walk) else $error("phase walk");
  // a table read holds the pc, so no step is also legal
  chk_pc_step: assert property (
    q1 |=> program_counter_o == $past(program_counter_o) + PC_STEP
    || $stable(program_counter_o)) else $error("pc step");
  chk_pc_edges: assert property (
    $changed(program_counter_o) |-> $past(q1q4)) else $error("pc edge");
  chk_pc_even: assert property (
    program_counter_o[0] == 1'b0) else $error("pc odd");
  chk_addr_q1: assert property (
    $changed(pmem_addr_o) |-> $past(q1)) else $error("addr edge");
  chk_addr_stands: assert property (
    $changed(pmem_addr_o) |=> $stable(pmem_addr_o) [*3])
    else $error("addr hold");
  chk_read_q2: assert property (
    dmem_re_o |-> $past(q2)) else $error("read phase");
  chk_write_q4: assert property (
    dmem_we_o |-> $past(q4)) else $error("write phase");
endmodule
bind fetch_pipe fetch_pipe_properties chk_u (.clk_i, .reset_n_i,
  .phase_clk_o, .pmem_addr_o, .dmem_re_o, .dmem_we_o, .program_counter_o);

// ### verif/mem_model.sv
`timescale 1ns/10ps
module mem_model
  import fetch_pipe_pkg::*;
(
  input wire logic clk_i,
  input wire logic [PC_W-2:0] pmem_addr_i,
  output logic [PW_W-1:0] pmem_rdata_o,
  input wire logic [DA_W-1:0] dmem_addr_i,
  input wire logic dmem_re_i,
  input wire logic dmem_we_i,
  input wire logic [DB_W-1:0] dmem_wdata_i,
  output logic [DB_W-1:0] dmem_rdata_o
);
  logic [PW_W-1:0] rom [0:511];
  logic [DB_W-1:0] ram [0:4095];
  // word-wide rom, one cycle behind the address
  always_ff @(posedge clk_i) begin
    pmem_rdata_o <= rom[pmem_addr_i[8:0]];
  end
  // junk outside a read so a late sample cannot pass by luck
  assign dmem_rdata_o = dmem_re_i ? ram[dmem_addr_i] : ~ram[dmem_addr_i];
  always_ff @(posedge clk_i) begin
    if (dmem_we_i) begin
      ram[dmem_addr_i] <= dmem_wdata_i;
    end
  end
endmodule

// ### verif/fetch_pipe_tb.sv
`timescale 1ns/10ps
module fetch_pipe_tb import fetch_pipe_pkg::*;;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] bank_i = 4'h0;
  logic [PC_W-1:0] tos_i = 21'h000050;
  logic [PC_W-1:0] table_pointer_i = 21'h000201;
  logic [PW_W-1:0] pmem_rdata_i;
  logic [DB_W-1:0] dmem_rdata_i, dmem_wdata_o, table_latch_o;
  logic [DB_W-1:0] working_register_o, wr_data = 8'h00;
  logic [3:0] phase_clk_o;
  logic [PC_W-2:0] pmem_addr_o;
  logic [DA_W-1:0] dmem_addr_o, pointer_value_o;
  logic [DA_W-1:0] wr_addr = 12'h000, pval = 12'h000;
  logic dmem_re_o, dmem_we_o, stack_push_o, stack_pop_o, pointer_load_o;
  logic popped = 1'b0;
  logic [1:0] pointer_sel_o, psel = 2'h0;
  logic [PC_W-1:0] return_addr_o, program_counter_o, ret_addr = 21'h0;
  int mismatches = 0;
  int n_checks = 0;
  // word address in the top half, program word below
  logic [31:0] prog [21] = '{32'h00000e55, 32'h00012610, 32'h0002ef20,
    32'h0003f000, 32'h00040eaa, 32'h0020d001, 32'h00210eaa, 32'h0022f0e5,
    32'h0023ee11, 32'h0024f023, 32'h00250e04, 32'h0026ec40,
    32'h0027f000, 32'h00280008, 32'h0029ef29, 32'h002af000, 32'h004026f9,
    32'h00410c66, 32'h00420c66, 32'h00430c77, 32'h0100beef};

  fetch_pipe uut (.clk_i, .reset_n_i, .pmem_rdata_i, .dmem_rdata_i, .bank_i,
    .tos_i, .table_pointer_i, .phase_clk_o, .pmem_addr_o, .dmem_addr_o,
    .dmem_re_o, .dmem_we_o, .dmem_wdata_o, .stack_push_o, .stack_pop_o,
    .return_addr_o, .table_latch_o, .pointer_load_o, .pointer_sel_o,
    .pointer_value_o, .working_register_o, .program_counter_o);
  mem_model mem (.clk_i, .pmem_addr_i(pmem_addr_o),
    .pmem_rdata_o(pmem_rdata_i), .dmem_addr_i(dmem_addr_o),
    .dmem_re_i(dmem_re_o), .dmem_we_i(dmem_we_o),
    .dmem_wdata_i(dmem_wdata_o), .dmem_rdata_o(dmem_rdata_i));

  always #2 clk_i = ~clk_i;

  // pulses last one cycle, so keep what they carried
  always @(posedge clk_i) begin
    if (dmem_we_o === 1'b1) begin
      wr_data <= dmem_wdata_o;
      wr_addr <= dmem_addr_o;
    end
    if (stack_push_o === 1'b1) ret_addr <= return_addr_o;
    if (pointer_load_o === 1'b1) begin
      psel <= pointer_sel_o;
      pval <= pointer_value_o;
    end
    if (stack_pop_o === 1'b1) popped <= 1'b1;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_addr(input logic [PC_W-2:0] a);
    for (int i = 0; i < 500 && pmem_addr_o !== a; i++) begin
      @(posedge clk_i);
      #1;
    end
    check("pmem_addr", 32'(pmem_addr_o), 32'(a));
    if (pmem_addr_o !== a) wrap_up();
  endtask

  task automatic t_reset();
    @(posedge clk_i);
    #1;
    check("pc", 32'(program_counter_o), 32'h2);
    check("addr", 32'(pmem_addr_o), 32'h0);
    check("phase", 32'(phase_clk_o), 32'h2);
  endtask

  task automatic t_jump();
    wait_addr(20'h00020);
    wait_addr(20'h00023);
    check("w", 32'(working_register_o), 32'h55);
  endtask

  task automatic t_alu();
    check("wdata", 32'(wr_data), 32'h58);
    check("waddr", 32'(wr_addr), 32'h010);
  endtask

  task automatic t_pair();
    wait_addr(20'h00026);
    check("sel", 32'(psel), 32'h1);
    check("val", 32'(pval), 32'h123);
    check("w", 32'(working_register_o), 32'h55);
  endtask

  task automatic t_table();
    wait_addr(20'h00040);
    check("ret", 32'(ret_addr), 32'h50);
    wait_addr(20'h00043);
    wait_addr(20'h00028);
    check("w", 32'(working_register_o), 32'h77);
    check("pop", 32'(popped), 32'h1);
    wait_addr(20'h00100);
    repeat (8) @(posedge clk_i);
    check("latch", 32'(table_latch_o), 32'hbe);
  endtask

  initial begin
    for (int i = 0; i < 512; i++) mem.rom[i] = 16'h0000;
    for (int i = 0; i < 21; i++) mem.rom[prog[i][24:16]] = prog[i][15:0];
    mem.ram[12'h010] = 8'h03;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_jump();
    t_alu();
    t_pair();
    t_table();
    wrap_up();
  end
endmodule
